// file: common/rscb_pkg.sv
// Package of constants for the reset source combiner with brown-out control
package rscb_pkg;
   // APB byte offsets
   localparam logic [11:0] OFF_CAUSE  = 12'h000;
   localparam logic [11:0] OFF_CONFIG = 12'h004;
   localparam logic [11:0] OFF_STATUS = 12'h008;
   localparam logic [11:0] OFF_IRQST  = 12'h00C;
   localparam logic [11:0] OFF_IRQMSK = 12'h010;
   localparam logic [11:0] OFF_RETAIN = 12'h014;
   localparam logic [11:0] OFF_CALIB  = 12'h018;
   localparam logic [11:0] OFF_NVCTRL = 12'h01C;
   // Cause register bit positions
   localparam int B_POR    = 0;
   localparam int B_BOR    = 1;
   localparam int B_SWR    = 6;
   localparam int B_EXTR   = 7;
   localparam int B_WDT    = 4;
   localparam int B_SW_BROWNOUT_ENABLE = 13;
   localparam int B_IOP    = 14;
   localparam int B_TRAP   = 15;
   localparam int B_UWR    = 9;
   localparam logic [15:0] CAUSE_WMASK = 16'hE2D3;
   localparam logic [15:0] CAUSE_POR_VAL = 16'h0003;
   // Brown-out mode field values
   localparam logic [1:0] BMODE_OFF = 2'h0;
   localparam logic [1:0] BMODE_SW  = 2'h1;
   // Reset source indices
   localparam int SRC_N = 8;
   localparam int S_POR = 0;
   localparam int S_EXT = 1;
   localparam int S_SWR = 2;
   localparam int S_WDT = 3;
   localparam int S_BOR = 4;
   localparam int S_TRP = 5;
   localparam int S_IOP = 6;
   localparam int S_UWR = 7;
   // Power-up delay time
   localparam int CLK_MHZ = 100;
   localparam int POWERUP_DELAY_TIMER_US = 64;
   localparam int POWERUP_DELAY_TIMER_CYC = POWERUP_DELAY_TIMER_US * CLK_MHZ;
   localparam int POWERUP_DELAY_TIMER_W = 16;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   typedef enum logic [2:0] {
      RSCB_HOLD = 3'b001,
      RSCB_WCLK = 3'b010,
      RSCB_RUN  = 3'b100
   } rscb_state_e;
endpackage : rscb_pkg

// file: design/rscb_powerup_delay_timer.sv
// Power-up delay counter, restarts whenever brown-out is active while its enable is set
`timescale 1ns/1ps
module rscb_powerup_delay_timer #(
   parameter int unsigned DELAY = rscb_pkg::POWERUP_DELAY_TIMER_CYC
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic enable,
   input  wire logic restart,
   output logic      busy
);
   logic [rscb_pkg::POWERUP_DELAY_TIMER_W-1:0] cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
      end else if (restart && enable) begin
         cnt_r <= rscb_pkg::POWERUP_DELAY_TIMER_W'(DELAY);
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end
   assign busy = (cnt_r != '0);
endmodule : rscb_powerup_delay_timer

// file: design/rscb_sync_pulse.sv
// Rising edge detector for one reset request
`timescale 1ns/1ps
module rscb_sync_pulse (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic level,
   output logic      rise
);
   logic prev_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= level;
      end
   end
   assign rise = level & ~prev_r;
endmodule : rscb_sync_pulse

// file: design/rscb_top.sv
// Reset source combiner with brown-out control and cause flags
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
module rscb_top #(
   parameter int unsigned POWERUP_DELAY_TIMER_DELAY = rscb_pkg::POWERUP_DELAY_TIMER_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        external_reset_pin,
   input  wire logic        sw_reset_req,
   input  wire logic        watchdog_req,
   input  wire logic        trap_conflict_req,
   input  wire logic        illegal_opcode_req,
   input  wire logic        uninit_wreg_req,
   input  wire logic        supply_low,
   input  wire logic [6:0]  reset_config_word,
   input  wire logic        powerup_timer_en,
   input  wire logic        clock_fail_monitor_en,
   input  wire logic        clock_valid,
   output logic [1:0]       brownout_level_out,
   output logic             system_reset_out,
   output logic             cpu_run,
   output logic             fast_osc_select,
   output logic             irq
);
   ////////////////////////////////////////////////////////////////////////////
   // Brown-out and source combination
   // config fields
   wire [1:0] brownout_level_field = reset_config_word[6:5];
   wire [1:0] brownout_mode_field  = reset_config_word[1:0];
   wire       mode_sw = (brownout_mode_field == rscb_pkg::BMODE_SW);
   logic [15:0] cause_r;
   wire bor_on = (brownout_mode_field != rscb_pkg::BMODE_OFF) &&
                 (!mode_sw || cause_r[rscb_pkg::B_SW_BROWNOUT_ENABLE]);
   wire bor_act = bor_on & supply_low;
   wire powerup_delay_timer_busy;
   // delay restarts only when its own enable is set
   rscb_powerup_delay_timer #(.DELAY(POWERUP_DELAY_TIMER_DELAY)) u_powerup_delay_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (powerup_timer_en),
      .restart (bor_act),
      .busy    (powerup_delay_timer_busy)
   );
   logic por_pend_r;
   wire [rscb_pkg::SRC_N-1:0] src;
   assign src[rscb_pkg::S_POR] = por_pend_r;
   assign src[rscb_pkg::S_EXT] = external_reset_pin;
   assign src[rscb_pkg::S_SWR] = sw_reset_req;
   assign src[rscb_pkg::S_WDT] = watchdog_req;
   assign src[rscb_pkg::S_BOR] = bor_act | powerup_delay_timer_busy;
   assign src[rscb_pkg::S_TRP] = trap_conflict_req;
   assign src[rscb_pkg::S_IOP] = illegal_opcode_req;
   assign src[rscb_pkg::S_UWR] = uninit_wreg_req;
   wire [rscb_pkg::SRC_N-1:0] rise;
   genvar gi;
   generate
      for (gi = 0; gi < rscb_pkg::SRC_N; gi++) begin : g_edge
         rscb_sync_pulse u_edge (
            .pclk    (pclk),
            .presetn (presetn),
            .level   (src[gi]),
            .rise    (rise[gi])
         );
      end
   endgenerate
   wire any_src = |src;
   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   wire acc    = psel & penable;
   wire wr     = acc & pwrite;
   wire rd     = acc & ~pwrite;
   wire hit_ca = (paddr == rscb_pkg::OFF_CAUSE);
   wire hit_cf = (paddr == rscb_pkg::OFF_CONFIG);
   wire hit_st = (paddr == rscb_pkg::OFF_STATUS);
   wire hit_is = (paddr == rscb_pkg::OFF_IRQST);
   wire hit_im = (paddr == rscb_pkg::OFF_IRQMSK);
   wire hit_rt = (paddr == rscb_pkg::OFF_RETAIN);
   wire hit_cb = (paddr == rscb_pkg::OFF_CALIB);
   wire hit_nv = (paddr == rscb_pkg::OFF_NVCTRL);
   wire hit_any = hit_ca | hit_cf | hit_st | hit_is | hit_im | hit_rt | hit_cb | hit_nv;
   wire [15:0] wlo = {pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00};
   wire [15:0] wmk = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   ////////////////////////////////////////////////////////////////////////////
   // Cause flags
   wire [15:0] hw_set = {rise[rscb_pkg::S_TRP], rise[rscb_pkg::S_IOP], 4'h0,
                         rise[rscb_pkg::S_UWR], 1'b0, rise[rscb_pkg::S_EXT],
                         rise[rscb_pkg::S_SWR], 1'b0, rise[rscb_pkg::S_WDT],
                         2'h0, rise[rscb_pkg::S_BOR], 1'b0};
   wire [15:0] sw_mask = (wr && hit_ca) ? (wmk & rscb_pkg::CAUSE_WMASK) : 16'h0000;
   wire [15:0] cause_nxt = ((cause_r & ~sw_mask) | (wlo & sw_mask)) | hw_set;
   // software bit reads zero outside mode 01
   wire [15:0] cause_view = mode_sw ? cause_r
                          : (cause_r & ~(16'h0001 << rscb_pkg::B_SW_BROWNOUT_ENABLE));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_r <= rscb_pkg::CAUSE_POR_VAL;
      end else begin
         cause_r <= cause_nxt;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_pend_r <= 1'b1;
      end else begin
         por_pend_r <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Retained and power-on-only registers
   // retained word: never touched by system reset
   logic [31:0] retain_r;
   logic [15:0] calib_r;
   logic [15:0] nvctrl_r;
   logic [7:0]  irq_st_r;
   logic [7:0]  irq_mk_r;
   always_ff @(posedge pclk) begin
      if (wr && hit_rt) begin
         retain_r <= pwdata;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         calib_r  <= 16'h0000;
         nvctrl_r <= 16'h0000;
      end else begin
         if (wr && hit_cb) begin
            calib_r <= (calib_r & ~wmk) | wlo;
         end
         if (wr && hit_nv) begin
            nvctrl_r <= (nvctrl_r & ~wmk) | wlo;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Interrupt: read of status clears, set wins
   // Clear only the bits the read returned, so an event landing mid-read is kept
   wire [7:0] irq_clr = (rd && hit_is) ? prdata[7:0] : 8'h00;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_st_r <= 8'h00;
         irq_mk_r <= 8'h00;
      end else begin
         irq_st_r <= (irq_st_r & ~irq_clr) | rise;
         if (wr && hit_im) begin
            irq_mk_r <= pwdata[7:0];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Release sequence
   rscb_pkg::rscb_state_e st_r, st_nxt;
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         rscb_pkg::RSCB_HOLD: if (!any_src) st_nxt = rscb_pkg::RSCB_WCLK;
         rscb_pkg::RSCB_WCLK: begin
            if (any_src) st_nxt = rscb_pkg::RSCB_HOLD;
            else if (clock_valid || clock_fail_monitor_en) st_nxt = rscb_pkg::RSCB_RUN;
         end
         rscb_pkg::RSCB_RUN: if (any_src) st_nxt = rscb_pkg::RSCB_HOLD;
         default: st_nxt = rscb_pkg::RSCB_HOLD;
      endcase
   end
   logic [31:0] rdata_nxt;
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (1'b1)
         hit_ca: rdata_nxt = {16'h0000, cause_view};
         hit_cf: rdata_nxt = {25'h0, reset_config_word};
         hit_st: rdata_nxt = {24'h0, bor_act, powerup_delay_timer_busy, fast_osc_select,
                              cpu_run, 1'b0, st_r};
         hit_is: rdata_nxt = {24'h0, irq_st_r};
         hit_im: rdata_nxt = {24'h0, irq_mk_r};
         hit_rt: rdata_nxt = retain_r;
         hit_cb: rdata_nxt = {16'h0000, calib_r};
         hit_nv: rdata_nxt = {16'h0000, nvctrl_r};
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r               <= rscb_pkg::RSCB_HOLD;
         system_reset_out   <= 1'b1;
         cpu_run            <= 1'b0;
         fast_osc_select    <= 1'b0;
         irq                <= 1'b0;
         brownout_level_out <= 2'h0;
         prdata             <= rscb_pkg::RESET_WORD;
         pready             <= 1'b0;
         pslverr            <= 1'b0;
      end else begin
         st_r               <= st_nxt;
         system_reset_out   <= any_src;
         cpu_run            <= (st_nxt == rscb_pkg::RSCB_RUN);
         // switch when no valid clock at release
         if (st_r == rscb_pkg::RSCB_WCLK && st_nxt == rscb_pkg::RSCB_RUN) begin
            fast_osc_select <= ~clock_valid;
         end
         irq                <= |((irq_st_r & ~irq_clr | rise) & irq_mk_r);
         brownout_level_out <= brownout_level_field;
         pready             <= psel & ~penable;
         pslverr            <= psel & ~penable & ~hit_any;
         if (psel && !penable && !pwrite) begin
            prdata <= rdata_nxt;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_src_high;
      any_src;
   endsequence
   sequence s_reset_out;
      ##1 system_reset_out;
   endsequence
   chk_reset_follows: assert property (@(posedge pclk) disable iff (!presetn)
      s_src_high |-> s_reset_out) else $error("reset output missed a source");
   chk_wdt_flag: assert property (@(posedge pclk) disable iff (!presetn)
      rise[rscb_pkg::S_WDT] |=> cause_r[rscb_pkg::B_WDT]) else $error("watchdog flag not set");
   chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      (rise[rscb_pkg::S_EXT] && wr && hit_ca) |=> cause_r[rscb_pkg::B_EXTR])
      else $error("software clear beat hardware set");
   chk_sw_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit_ca && pstrb[0] && hw_set == 16'h0000) |=>
      cause_r[rscb_pkg::B_SWR] == $past(pwdata[rscb_pkg::B_SWR]))
      else $error("software write not stored");
   chk_bor_reset: assert property (@(posedge pclk) disable iff (!presetn)
      bor_act |=> system_reset_out) else $error("brown-out did not reset");
   chk_bor_hold: assert property (@(posedge pclk) disable iff (!presetn)
      bor_act [*3] |=> !cpu_run) else $error("ran during brown-out");
   chk_powerup_delay_timer_restart: assert property (@(posedge pclk) disable iff (!presetn)
      (bor_act && powerup_timer_en) |=> powerup_delay_timer_busy) else $error("delay not restarted");
   chk_powerup_delay_timer_indep: assert property (@(posedge pclk) disable iff (!presetn)
      (!powerup_timer_en && !powerup_delay_timer_busy) |=> !powerup_delay_timer_busy) else $error("delay ran unenabled");
   chk_sbor_zero: assert property (@(posedge pclk) disable iff (!presetn)
      !mode_sw |-> !cause_view[rscb_pkg::B_SW_BROWNOUT_ENABLE]) else $error("software bit visible");
   chk_run_clock: assert property (@(posedge pclk) disable iff (!presetn)
      (cpu_run && !$past(cpu_run)) |-> ($past(clock_valid) || $past(clock_fail_monitor_en)))
      else $error("run without valid clock");
   ////////////////////////////////////////////////////////////////////////////
   // Helper count for the delay length check
   logic [rscb_pkg::POWERUP_DELAY_TIMER_W-1:0] powerup_delay_timer_seen_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         powerup_delay_timer_seen_r <= '0;
      end else if (bor_act || !powerup_delay_timer_busy) begin
         powerup_delay_timer_seen_r <= '0;
      end else begin
         powerup_delay_timer_seen_r <= powerup_delay_timer_seen_r + 1'b1;
      end
   end
   sequence s_fail_release;
      st_r == rscb_pkg::RSCB_WCLK && !any_src && clock_fail_monitor_en && !clock_valid;
   endsequence
   sequence s_run_fast;
      ##1 cpu_run && fast_osc_select;
   endsequence
   sequence s_no_clock;
      st_r == rscb_pkg::RSCB_WCLK && !clock_valid && !clock_fail_monitor_en;
   endsequence
   // full delay after the last dip
   chk_powerup_delay_timer_length: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(powerup_delay_timer_busy) |-> powerup_delay_timer_seen_r == POWERUP_DELAY_TIMER_DELAY)
      else $error("power-up delay length wrong");
   chk_fast_osc: assert property (@(posedge pclk) disable iff (!presetn)
      s_fail_release |-> s_run_fast) else $error("fast oscillator not selected");
   chk_wait_clock: assert property (@(posedge pclk) disable iff (!presetn)
      s_no_clock |=> !cpu_run) else $error("ran before clock was valid");
   chk_sbor_off: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_sw && !cause_r[rscb_pkg::B_SW_BROWNOUT_ENABLE]) |-> !bor_act)
      else $error("brown-out active with software bit clear");
   chk_mode_off: assert property (@(posedge pclk) disable iff (!presetn)
      (brownout_mode_field == rscb_pkg::BMODE_OFF) |-> !bor_act)
      else $error("brown-out active in mode off");
   chk_level_copy: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> brownout_level_out == $past(brownout_level_field))
      else $error("level output not from configuration");
   chk_trap_flag: assert property (@(posedge pclk) disable iff (!presetn)
      rise[rscb_pkg::S_TRP] |=> cause_r[rscb_pkg::B_TRAP]) else $error("trap flag not set");
   // Ready answers every setup cycle, one cycle wide
   chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready) else $error("ready missing");
   chk_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !(psel && !penable) |=> !pready) else $error("ready outside access");
   // Unmapped reads answer zero with an error
   chk_unmapped_rd: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && !hit_any) |=>
      (pslverr && prdata == 32'h0000_0000)) else $error("unmapped read not refused");
   // Status read clears what it returned
   chk_irq_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (rd && hit_is && rise == 8'h00) |=> (irq_st_r & $past(prdata[7:0])) == 8'h00)
      else $error("interrupt status not cleared");
endmodule : rscb_top

// file: verif/rscb_req_model.sv
// Model of the reset requesters: one level request held for a set count
`timescale 1ns/1ps
module rscb_req_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       go,
   input  wire logic [2:0] src,
   input  wire logic [3:0] hold,
   output logic      [7:0] req
);
   logic [3:0] cnt_r;
   ////////////////////////////////////////////////////////////////////////////////
   // one source at a time
   // A new request is ignored until the previous one drops, as a real source would
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req   <= 8'h00;
         cnt_r <= 4'h0;
      end else if (go && cnt_r == 4'h0) begin
         req      <= 8'h00;
         req[src] <= 1'b1;
         cnt_r    <= hold;
      end else if (cnt_r > 4'h1) begin
         cnt_r <= cnt_r - 4'h1;
      end else begin
         req   <= 8'h00;
         cnt_r <= 4'h0;
      end
   end
endmodule : rscb_req_model

// file: verif/tb.sv
// Self-checking bench for the reset source combiner
`timescale 1ns/1ps
module tb;
   localparam int unsigned DLY = 8;
   logic        pclk, presetn, psel, penable, pwrite, supply_low, powerup_delay_timer_en, mon_en, clk_ok;
   logic        go, pready, pslverr, irq, system_reset_out, cpu_run, fast_osc_select, serr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat, d;
   logic [6:0]  cfg;
   logic [2:0]  src;
   logic [3:0]  hold;
   logic [7:0]  req;
   logic [1:0]  lvl;
   int          err_total, n_tests, seed, i, n, off;
   int          srcs [6];
   rscb_top #(.POWERUP_DELAY_TIMER_DELAY(DLY)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_reset_pin(req[rscb_pkg::S_EXT]), .sw_reset_req(req[rscb_pkg::S_SWR]),
      .watchdog_req(req[rscb_pkg::S_WDT]), .trap_conflict_req(req[rscb_pkg::S_TRP]),
      .illegal_opcode_req(req[rscb_pkg::S_IOP]), .uninit_wreg_req(req[rscb_pkg::S_UWR]),
      .supply_low(supply_low), .reset_config_word(cfg), .powerup_timer_en(powerup_delay_timer_en),
      .clock_fail_monitor_en(mon_en), .clock_valid(clk_ok), .brownout_level_out(lvl),
      .system_reset_out(system_reset_out), .cpu_run(cpu_run),
      .fast_osc_select(fast_osc_select), .irq(irq));
   rscb_req_model req_u (.pclk(pclk), .presetn(presetn), .go(go), .src(src), .hold(hold),
      .req(req));
   always #5 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] cause_of(input int s);
      case (s)
         rscb_pkg::S_EXT: cause_of = 32'h1 << rscb_pkg::B_EXTR;
         rscb_pkg::S_SWR: cause_of = 32'h1 << rscb_pkg::B_SWR;
         rscb_pkg::S_WDT: cause_of = 32'h1 << rscb_pkg::B_WDT;
         rscb_pkg::S_TRP: cause_of = 32'h1 << rscb_pkg::B_TRAP;
         rscb_pkg::S_IOP: cause_of = 32'h1 << rscb_pkg::B_IOP;
         default:         cause_of = 32'h1 << rscb_pkg::B_UWR;
      endcase
   endfunction : cause_of
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      serr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task fire(input int s, input logic [3:0] h);
      @(posedge pclk);
      src  <= s[2:0];
      hold <= h;
      go   <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
   endtask : fire
   task wait_rel;
      n = 0;
      while (system_reset_out !== 1'b0 && n < 300) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 300) begin
         err_total++;
         $display("[ERR] %0t reset never released", $time);
      end
   endtask : wait_rel
   task wait_run;
      n = 0;
      while (cpu_run !== 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
   endtask : wait_run
   task brown;
      supply_low <= 1'b1;
      repeat (6) @(posedge pclk);
      supply_low <= 1'b0;
      wait_rel();
   endtask : brown
   task results;
      $display("mismatches %0d comparisons %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      err_total++;
      results();
   end
   initial begin
      seed = 32'h3104087a;
      srcs = '{rscb_pkg::S_EXT, rscb_pkg::S_SWR, rscb_pkg::S_WDT, rscb_pkg::S_TRP,
               rscb_pkg::S_IOP, rscb_pkg::S_UWR};
      {pclk, presetn, psel, penable, pwrite, supply_low, powerup_delay_timer_en, mon_en, clk_ok} = '0;
      {go, src, hold, paddr, pwdata} = '0;
      cfg = {2'($random(seed)), 5'h00};
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (20) @(posedge pclk);
      chk(cpu_run, 1'b0, "run without clock");
      clk_ok <= 1'b1;
      wait_run();
      chk(cpu_run, 1'b1, "run with clock");
      chk(lvl, cfg[6:5], "level field");
      apb(1'b0, rscb_pkg::OFF_CAUSE, 32'h0);
      chk(rdat, 32'h0003, "power-on cause");
      apb(1'b1, rscb_pkg::OFF_CAUSE, 32'hC2D3 | 32'h2000);
      repeat (4) @(posedge pclk);
      chk(system_reset_out, 1'b0, "software flags no reset");
      apb(1'b0, rscb_pkg::OFF_CAUSE, 32'h0);
      chk(rdat, 32'hC2D3, "software flags, enable bit zero");
      off = {$random(seed)} % 6;
      for (i = 0; i < 6; i++) begin
         apb(1'b1, rscb_pkg::OFF_CAUSE, 32'h0);
         fire(srcs[(i + off) % 6], 4'h4 + 4'({$random(seed)} % 8));
         repeat (3) @(posedge pclk);
         chk(system_reset_out, 1'b1, "source asserts reset");
         wait_rel();
         apb(1'b0, rscb_pkg::OFF_CAUSE, 32'h0);
         chk(rdat, cause_of(srcs[(i + off) % 6]), "source flag");
      end
      // Request edge and clearing write meet at the same clock edge
      fork
         fire(rscb_pkg::S_EXT, 4'h4);
         apb(1'b1, rscb_pkg::OFF_CAUSE, 32'h0);
      join
      repeat (3) @(posedge pclk);
      wait_rel();
      apb(1'b0, rscb_pkg::OFF_CAUSE, 32'h0);
      chk(rdat, cause_of(rscb_pkg::S_EXT), "set beats clearing write");
      brown();
      chk(n == 0, 1'b1, "mode off ignores supply");
      cfg[1:0] <= 2'h3;
      powerup_delay_timer_en  <= 1'b1;
      supply_low <= 1'b1;
      repeat (6) @(posedge pclk);
      chk(system_reset_out, 1'b1, "held while supply low");
      supply_low <= 1'b0;
      repeat (4) @(posedge pclk);
      supply_low <= 1'b1;
      repeat (3) @(posedge pclk);
      supply_low <= 1'b0;
      wait_rel();
      chk(n >= DLY && n <= DLY + 4, 1'b1, "delay restarts after dip");
      powerup_delay_timer_en <= 1'b0;
      brown();
      chk(n <= 4, 1'b1, "no delay when timer off");
      cfg[1:0] <= 2'h1;
      apb(1'b1, rscb_pkg::OFF_CAUSE, 32'h0);
      brown();
      chk(n == 0, 1'b1, "software bit clear disables");
      apb(1'b1, rscb_pkg::OFF_CAUSE, 32'h2000);
      brown();
      chk(n == 2, 1'b1, "software bit set enables");
      apb(1'b0, rscb_pkg::OFF_CAUSE, 32'h0);
      chk(rdat, 32'h2002, "brown-out flag and enable bit");
      apb(1'b1, rscb_pkg::OFF_IRQMSK, 32'hFF);
      apb(1'b0, rscb_pkg::OFF_IRQST, 32'h0);
      fire(rscb_pkg::S_WDT, 4'h4);
      repeat (3) @(posedge pclk);
      wait_rel();
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1, "interrupt raised");
      apb(1'b0, rscb_pkg::OFF_IRQST, 32'h0);
      chk(rdat[rscb_pkg::S_WDT], 1'b1, "interrupt status");
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0, "read clears interrupt");
      apb(1'b1, rscb_pkg::OFF_IRQMSK, 32'h0);
      fire(rscb_pkg::S_EXT, 4'h4);
      repeat (3) @(posedge pclk);
      wait_rel();
      chk(irq, 1'b0, "masked interrupt");
      apb(1'b0, 12'h020, 32'h0);
      chk(rdat, 32'h0, "unmapped address reads zero");
      chk(serr, 1'b1, "unmapped address error");
      d = 32'($random(seed)) & 32'hFFFF;
      apb(1'b1, rscb_pkg::OFF_RETAIN, d);
      apb(1'b1, rscb_pkg::OFF_CALIB, d ^ 32'hFFFF);
      clk_ok <= 1'b0;
      mon_en <= 1'b1;
      fire(rscb_pkg::S_SWR, 4'h4);
      repeat (3) @(posedge pclk);
      wait_rel();
      wait_run();
      chk({cpu_run, fast_osc_select}, 2'b11, "monitor selects fast osc");
      apb(1'b0, rscb_pkg::OFF_RETAIN, 32'h0);
      chk(rdat, d, "retained across reset");
      apb(1'b0, rscb_pkg::OFF_CALIB, 32'h0);
      chk(rdat, d ^ 32'hFFFF, "calibration kept");
      apb(1'b1, rscb_pkg::OFF_CAUSE, 32'h00C0);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      wait_rel();
      apb(1'b0, rscb_pkg::OFF_CAUSE, 32'h0);
      chk(rdat, 32'h0003, "second power-on cause");
      results();
   end
endmodule : tb
